// *** rtl/nswp_consts.svh ***
`ifndef NSWP_CONSTS_SVH
`define NSWP_CONSTS_SVH

// ------------------------------------------------------------
// Opcode fields
// ------------------------------------------------------------
`define NSWP_OP_W          14
`define NSWP_SWAP_HI       13
`define NSWP_SWAP_LO       8
`define NSWP_SWAP_PAT      6'hE
`define NSWP_DEST_BIT      7
`define NSWP_LDIR_HI       13
`define NSWP_LDIR_LO       3
`define NSWP_LDIR_PAT      11'h00C
`define NSWP_ADDR_HI       6
`define NSWP_DIR_SEL_HI    2

// ------------------------------------------------------------
// Direction register addresses and reset value
// ------------------------------------------------------------
`define NSWP_DIR_FIRST     3'h5
`define NSWP_DIR_LAST      3'h7
`define NSWP_DIR_COUNT     3
`define NSWP_DIR_RESET     8'hFF
`define NSWP_DIR_BANK_ADDR 7'h00
`define NSWP_ADDR_DIR_MASK 7'h78
`define NSWP_WORDS         1

`endif

// *** rtl/nswp_pkg.sv ***
package nswp_pkg;
    // Which instruction the decoder recognised this cycle
    typedef enum logic [1:0] {
        NSWP_OP_NONE,
        NSWP_OP_SWAP,
        NSWP_OP_LDIR
    } nswp_op_type;
endpackage

// *** rtl/nswp_dir_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nswp_consts.svh"

// One port direction register; several are instantiated by the exec block.
module nswp_dir_reg #(
    parameter int          WIDTH = 8,
    parameter logic [7:0]  RESET = `NSWP_DIR_RESET
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Write port
    input  wire logic             we_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Current value
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] val_r;
    logic [WIDTH-1:0] val_nxt;

    // ------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------
    always_comb begin
        val_nxt = we_i ? wdata_i : val_r;
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            val_r <= RESET[WIDTH-1:0];
        end else begin
            val_r <= val_nxt;
        end
    end

    assign q_o = val_r;

endmodule
`default_nettype wire

// *** rtl/nswp_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nswp_consts.svh"

module nswp_exec
    import nswp_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Instruction from the decoder, valid for one instruction cycle
    input  wire logic                      instr_valid_i,
    input  wire logic [`NSWP_OP_W-1:0]     instr_i,
    // Working register value
    input  wire logic [DATA_W-1:0]         w_i,
    // Register file read data for the addressed register
    input  wire logic [DATA_W-1:0]         rf_rdata_i,
    // Ordinary data-memory access to the direction bank
    input  wire logic                      dm_we_i,
    input  wire logic [ADDR_W-1:0]         dm_addr_i,
    input  wire logic [DATA_W-1:0]         dm_wdata_i,
    output logic      [DATA_W-1:0]         dm_dir_rdata_o,
    output logic                           dm_dir_hit_o,
    // Register file access driven by this block
    output logic      [ADDR_W-1:0]         rf_addr_o,
    output logic                           rf_we_o,
    output logic      [DATA_W-1:0]         rf_wdata_o,
    // Working register update
    output logic                           w_we_o,
    output logic      [DATA_W-1:0]         w_wdata_o,
    // Status flags: always left alone by these instructions
    output logic                           status_we_o,
    // Recognised instruction, for the core sequencer
    output logic                           claimed_o,
    // Direction registers towards the port logic
    output logic      [`NSWP_DIR_COUNT*DATA_W-1:0] dir_o
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // The swap and load-direction patterns never overlap, so the
    // priority in the decode below only matters for readability
    nswp_op_type       op;
    logic              swap_hit;
    logic              ldir_hit;
    logic [2:0]        dir_sel;
    logic [DATA_W-1:0] swapped;

    // Raw pattern matches, before the valid strobe is applied
    assign swap_hit = (instr_i[`NSWP_SWAP_HI:`NSWP_SWAP_LO] == `NSWP_SWAP_PAT);
    assign ldir_hit = (instr_i[`NSWP_LDIR_HI:`NSWP_LDIR_LO] == `NSWP_LDIR_PAT);

    // Nothing is recognised without the valid strobe, so a bubble in
    // the pipeline can never write anything
    always_comb begin
        op = NSWP_OP_NONE;
        if (instr_valid_i) begin
            if (swap_hit) begin
                op = NSWP_OP_SWAP;
            end else if (ldir_hit) begin
                op = NSWP_OP_LDIR;
            end
        end
    end

    // ------------------------------------------------------------
    // Operand fields and the swap datapath
    // ------------------------------------------------------------
    // Direction register number carried by the load-direction opcode
    assign dir_sel = instr_i[`NSWP_DIR_SEL_HI:0];
    // Nibble exchange is pure wiring, so it fits the single cycle
    assign swapped = {rf_rdata_i[DATA_W/2-1:0], rf_rdata_i[DATA_W-1:DATA_W/2]};

    // The source address is offered every cycle; the register file only
    // acts on it when a swap is decoded
    assign rf_addr_o = instr_i[`NSWP_ADDR_HI:0];

    // ------------------------------------------------------------
    // Destination steering, registered so data outputs are flops
    // ------------------------------------------------------------
    // The write pulses last one cycle; the data words keep their last
    // value, so a late sampler in the core still sees a settled byte
    // Register file write-back
    logic              rf_we_r, rf_we_nxt;
    logic [DATA_W-1:0] rf_wdata_r, rf_wdata_nxt;
    // Working register write
    logic              w_we_r, w_we_nxt;
    logic [DATA_W-1:0] w_wdata_r, w_wdata_nxt;

    // Next values: each swap picks exactly one destination
    always_comb begin
        rf_we_nxt    = 1'h0;
        rf_wdata_nxt = rf_wdata_r;
        w_we_nxt     = 1'h0;
        w_wdata_nxt  = w_wdata_r;
        case (op)
            NSWP_OP_SWAP: begin
                if (instr_i[`NSWP_DEST_BIT]) begin
                    rf_we_nxt    = 1'h1;
                    rf_wdata_nxt = swapped;
                end else begin
                    w_we_nxt    = 1'h1;          // Source untouched
                    w_wdata_nxt = swapped;
                end
            end
            NSWP_OP_LDIR: begin
                // The direction bank below takes this one; neither the
                // register file nor the working register is written
            end
            NSWP_OP_NONE: begin
            end
            default: begin
            end
        endcase
    end

    // Registers only; the reset clears both pulses and both data words
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rf_we_r    <= 1'h0;
            rf_wdata_r <= '0;
            w_we_r     <= 1'h0;
            w_wdata_r  <= '0;
        end else begin
            rf_we_r    <= rf_we_nxt;
            rf_wdata_r <= rf_wdata_nxt;
            w_we_r     <= w_we_nxt;
            w_wdata_r  <= w_wdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rf_we_o    = rf_we_r;
    assign rf_wdata_o = rf_wdata_r;
    assign w_we_o     = w_we_r;
    assign w_wdata_o  = w_wdata_r;
    // Neither instruction touches the flags
    assign status_we_o = 1'h0;
    // One word, decided in the cycle it is presented
    assign claimed_o = (op != NSWP_OP_NONE);

    // ------------------------------------------------------------
    // Direction bank address decode
    // ------------------------------------------------------------
    // The bank answers at data addresses 5 to 7 only; the mask check
    // keeps other pages from aliasing onto it through the low bits
    logic              dm_dir_bank;
    logic              ldir_in_range;
    // Current direction values, one entry per port
    logic [DATA_W-1:0] dir_q [`NSWP_DIR_COUNT];

    assign dm_dir_bank = ((dm_addr_i & `NSWP_ADDR_DIR_MASK) == `NSWP_DIR_BANK_ADDR)
                         && (dm_addr_i[2:0] >= `NSWP_DIR_FIRST);

    // A load-direction target below 5 is dropped, so a stray legacy
    // opcode can never disturb a port's direction
    assign ldir_in_range = (op == NSWP_OP_LDIR)
                           && (dir_sel >= `NSWP_DIR_FIRST);

    // ------------------------------------------------------------
    // Direction registers: opcode path and direct-address path
    // ------------------------------------------------------------
    // The opcode is kept for old code; direct writes are the preferred
    // path since later cores may drop it
    // One small register per port keeps the reset value in one place
    genvar gi;
    generate
        for (gi = 0; gi < `NSWP_DIR_COUNT; gi++) begin : g_dir
            localparam logic [2:0] SEL = `NSWP_DIR_FIRST + 3'(gi);
            logic              hit_op;
            logic              hit_dm;
            logic              we;
            logic [DATA_W-1:0] wd;
            assign hit_op = ldir_in_range && (dir_sel == SEL);
            assign hit_dm = dm_we_i && dm_dir_bank && (dm_addr_i[2:0] == SEL);
            // The instruction wins if both land in one cycle; software that
            // mixes both paths on one register gets the opcode's value
            assign we = hit_op | hit_dm;
            assign wd = hit_op ? w_i : dm_wdata_i;
            nswp_dir_reg #(
                .WIDTH (DATA_W)
            ) u_dir (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .we_i    (we),
                .wdata_i (wd),
                .q_o     (dir_q[gi])
            );
            // Port 5 sits in the lowest byte of the flat bus
            assign dir_o[gi*DATA_W +: DATA_W] = dir_q[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Direct read of the direction bank
    // ------------------------------------------------------------
    // Outside the bank the data is forced to zero, so the core can OR
    // this port into its read mux without a separate select
    always_comb begin
        dm_dir_rdata_o = '0;
        dm_dir_hit_o   = dm_dir_bank;
        if (dm_dir_bank) begin
            dm_dir_rdata_o = dir_q[2'(dm_addr_i[2:0] - `NSWP_DIR_FIRST)];
        end
    end

endmodule
`default_nettype wire

// *** tb/nswp_exec_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// -----------------------------
// Port checker for the exec block
// -----------------------------
module nswp_exec_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0]  w_i,
    input wire logic [7:0]  rf_rdata_i,
    input wire logic        dm_we_i,
    input wire logic [6:0]  dm_addr_i,
    input wire logic [7:0]  dm_wdata_i,
    input wire logic [7:0]  dm_dir_rdata_o,
    input wire logic        dm_dir_hit_o,
    input wire logic [6:0]  rf_addr_o,
    input wire logic        rf_we_o,
    input wire logic [7:0]  rf_wdata_o,
    input wire logic        w_we_o,
    input wire logic [7:0]  w_wdata_o,
    input wire logic        status_we_o,
    input wire logic        claimed_o,
    input wire logic [23:0] dir_o
);
    // Own decode, kept apart from the design's
    logic       swp, swp_src, swp_w, ldir, ldir_ok, dm_in;
    logic [7:0] swapped;
    logic [4:0] lsel, dsel;
    assign swp     = instr_valid_i && instr_i[13:8] == 6'h0E;
    assign swp_src = swp && instr_i[7];
    assign swp_w   = swp && !instr_i[7];
    assign ldir    = instr_valid_i && instr_i[13:3] == 11'h00C;
    assign ldir_ok = ldir && instr_i[2:0] >= 3'h5;
    assign dm_in   = dm_addr_i inside {7'h05, 7'h06, 7'h07};
    assign swapped = {rf_rdata_i[3:0], rf_rdata_i[7:4]};
    assign lsel    = {instr_i[1:0] - 2'h1, 3'h0};
    assign dsel    = {dm_addr_i[1:0] - 2'h1, 3'h0};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_swap_to_src: assert property (
        swp_src |=> rf_we_o && !w_we_o && rf_wdata_o == $past(swapped)) else $error("swap to f");
    a_swap_to_w: assert property (
        swp_w |=> w_we_o && !rf_we_o && w_wdata_o == $past(swapped)) else $error("swap to w");
    a_rf_we_cause: assert property (
        rf_we_o |-> $past(swp_src)) else $error("stray source write");
    a_swap_claimed: assert property (
        swp |-> claimed_o && rf_addr_o == instr_i[6:0]) else $error("swap not claimed");
    a_ldir_write: assert property (
        ldir_ok |=> dir_o[$past(lsel) +: 8] == $past(w_i)) else $error("direction load");
    a_ldir_ignore: assert property (
        ldir && !ldir_ok && !dm_we_i |=> $stable(dir_o)) else $error("bad address taken");
    a_dm_write: assert property (
        dm_we_i && dm_in && !ldir_ok |=> dir_o[$past(dsel) +: 8] == $past(dm_wdata_i))
        else $error("direct write");
    a_dm_read: assert property (
        dm_in |-> dm_dir_hit_o && dm_dir_rdata_o == dir_o[dsel +: 8]) else $error("direct read");
    a_dm_miss: assert property (
        !dm_in |-> !dm_dir_hit_o && dm_dir_rdata_o == 8'h00) else $error("false hit");
    a_status_kept: assert property (
        !status_we_o) else $error("status written");
    a_claim_exact: assert property (
        claimed_o == (swp || ldir)) else $error("wrong claim");
    // Main scenarios reached
    c_swap_src: cover property (swp_src);
    c_ldir: cover property (ldir_ok);
    c_dm_clash: cover property (ldir_ok && dm_we_i && dm_in);
endmodule
bind nswp_exec nswp_exec_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .w_i(w_i), .rf_rdata_i(rf_rdata_i), .dm_we_i(dm_we_i), .dm_addr_i(dm_addr_i),
    .dm_wdata_i(dm_wdata_i), .dm_dir_rdata_o(dm_dir_rdata_o), .dm_dir_hit_o(dm_dir_hit_o),
    .rf_addr_o(rf_addr_o), .rf_we_o(rf_we_o), .rf_wdata_o(rf_wdata_o), .w_we_o(w_we_o),
    .w_wdata_o(w_wdata_o), .status_we_o(status_we_o), .claimed_o(claimed_o),
    .dir_o(dir_o));
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i, rst_i, instr_valid_i, dm_we_i, dm_dir_hit_o;
    logic        rf_we_o, w_we_o, status_we_o, claimed_o;
    logic [13:0] instr_i;
    logic [7:0]  w_i, rf_rdata_i, dm_wdata_i, dm_dir_rdata_o, rf_wdata_o, w_wdata_o;
    logic [6:0]  dm_addr_i, rf_addr_o;
    logic [23:0] dir_o;
    int          error_cnt, check_count;
    typedef struct packed {
        logic [13:0] ins;
        logic [7:0]  w, rd;
        logic        rfw, ww;
        logic [7:0]  d;
        logic [23:0] dir;
    } nswp_row_type;
    nswp_row_type r;
    // Back-to-back rows; the last three must leave everything alone
    nswp_row_type rows [9] = '{
        '{14'h0EA5, 8'h00, 8'hA5, 1'h1, 1'h0, 8'h5A, 24'hFFFFFF},
        '{14'h0E10, 8'h00, 8'h3C, 1'h0, 1'h1, 8'hC3, 24'hFFFFFF},
        '{14'h0E7F, 8'h00, 8'h0F, 1'h0, 1'h1, 8'hF0, 24'hFFFFFF},
        '{14'h0065, 8'h12, 8'h00, 1'h0, 1'h0, 8'h00, 24'hFFFF12},
        '{14'h0066, 8'h34, 8'h00, 1'h0, 1'h0, 8'h00, 24'hFF3412},
        '{14'h0067, 8'h56, 8'h00, 1'h0, 1'h0, 8'h00, 24'h563412},
        '{14'h0064, 8'h99, 8'h00, 1'h0, 1'h0, 8'h00, 24'h563412},
        '{14'h006D, 8'h77, 8'h00, 1'h0, 1'h0, 8'h00, 24'h563412},
        '{14'h06A5, 8'h77, 8'hA5, 1'h0, 1'h0, 8'h00, 24'h563412}};

    nswp_exec DUT (
        .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .w_i(w_i), .rf_rdata_i(rf_rdata_i), .dm_we_i(dm_we_i), .dm_addr_i(dm_addr_i),
        .dm_wdata_i(dm_wdata_i), .dm_dir_rdata_o(dm_dir_rdata_o), .dm_dir_hit_o(dm_dir_hit_o),
        .rf_addr_o(rf_addr_o), .rf_we_o(rf_we_o), .rf_wdata_o(rf_wdata_o), .w_we_o(w_we_o),
        .w_wdata_o(w_wdata_o), .status_we_o(status_we_o), .claimed_o(claimed_o),
        .dir_o(dir_o));

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    // ------------------
    // Shared tasks
    // ------------------
    task check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task drive(input logic [13:0] ins, input logic [7:0] w, input logic [7:0] rd,
               input logic we, input logic [6:0] a, input logic [7:0] d);
        instr_valid_i <= 1'h1;
        instr_i <= ins;
        w_i <= w;
        rf_rdata_i <= rd;
        dm_we_i <= we;
        dm_addr_i <= a;
        dm_wdata_i <= d;
    endtask
    task give_verdict();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Cut a hang short: the whole run needs well under 50 cycles
    initial begin
        #5000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {rst_i, instr_valid_i, dm_we_i} = 3'h4;
        {instr_i, w_i, rf_rdata_i, dm_addr_i, dm_wdata_i} = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        #1;
        check(dir_o, 24'hFFFFFF);
        for (int i = 0; i <= 9; i++) begin
            @(posedge clk_i);
            if (i < 9) drive(rows[i].ins, rows[i].w, rows[i].rd, 1'h0, 7'h00, 8'h00);
            else instr_valid_i <= 1'h0;
            if (i > 0) begin
                #1;
                r = rows[i-1];
                check(rf_we_o, r.rfw);
                check(w_we_o, r.ww);
                if (r.rfw) check(rf_wdata_o, r.d);
                if (r.ww) check(w_wdata_o, r.d);
                check(dir_o, r.dir);
                check(status_we_o, 1'h0);
            end
        end
        // Direct write, then read back at the same address
        @(posedge clk_i);
        drive(14'h0000, 8'h00, 8'h00, 1'h1, 7'h06, 8'h3C);
        @(posedge clk_i);
        dm_we_i <= 1'h0;
        #1;
        check(dir_o, 24'h563C12);
        check({dm_dir_hit_o, dm_dir_rdata_o}, 24'h13C);
        // Load and direct write on one register in one cycle: load wins
        @(posedge clk_i);
        drive(14'h0067, 8'hAA, 8'h00, 1'h1, 7'h07, 8'h55);
        @(posedge clk_i);
        drive(14'h0000, 8'h00, 8'h00, 1'h0, 7'h15, 8'h00);
        #1;
        check(dir_o, 24'hAA3C12);
        check({dm_dir_hit_o, dm_dir_rdata_o}, 24'h000);
        // Reset in mid-run restores the direction bank and clears the data
        @(posedge clk_i);
        rst_i <= 1'h1;
        @(posedge clk_i);
        rst_i <= 1'h0;
        drive(14'h0E80, 8'h00, 8'h96, 1'h0, 7'h05, 8'h00);
        #1;
        check(dir_o, 24'hFFFFFF);
        check({rf_we_o, w_we_o, rf_wdata_o, w_wdata_o}, 24'h000000);
        check({dm_dir_hit_o, dm_dir_rdata_o}, 24'h1FF);
        // First swap after release lands one cycle later
        @(posedge clk_i);
        instr_valid_i <= 1'h0;
        #1;
        check({rf_we_o, w_we_o, rf_wdata_o}, 24'h269);
        give_verdict();
    end
endmodule
`default_nettype wire
